// [design/brcs_sat_cnt.sv]
// Saturating up-counter with a pulse on the step that reaches full.
// Assumes inc_i is qualified by the caller.
`timescale 1ns/1ps
`default_nettype none
module brcs_sat_cnt #(
   parameter int unsigned W = 32
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic inc_i,
   output logic [W-1:0] count_o,
   output logic full_o
);
   localparam logic [W-1:0] MAX = '1;

   assign full_o = ce_i & inc_i & (count_o == MAX - 1'b1);

   // Holds at full instead of wrapping
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         count_o <= '0;
      end else if (ce_i && inc_i && count_o != MAX) begin
         count_o <= count_o + 1'b1;
      end
   end
endmodule // brcs_sat_cnt
`default_nettype wire

// [design/brcs_sticky.sv]
// Sticky status flag: set by hardware, cleared by software.
// Assumes set and clear are single-cycle qualified strobes.
`timescale 1ns/1ps
`default_nettype none
module brcs_sticky (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);
   // A set in the clearing cycle is kept
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         flag_o <= 1'b0;
      end else if (ce_i) begin
         flag_o <= set_i | (flag_o & ~clr_i);
      end
   end
endmodule // brcs_sticky
`default_nettype wire

// [design/brcs_top.sv]
// Receive side of a bit error-rate tester: counters, lock tracking, flags.
// Assumes one received bit per cycle with rx_bit_en_i high, and exp_bit_i
// from an external pattern regenerator aligned to the same bit.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module brcs_top
   import brcs_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic rx_bit_i,
   input wire logic rx_bit_en_i,
   input wire logic exp_bit_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   output logic searching_o,
   output logic in_sync_o,
   output logic irq_o
);

   // ***********************************************************
   // Declarations
   // ***********************************************************
   brcs_ctrl_s ctrl;
   brcs_flags_s flags;
   brcs_sync_e sync_state;
   logic bit_step;
   logic mismatch;
   logic err_step;
   logic [BIT_CNT_W-1:0] bit_count;
   logic [ERR_CNT_W-1:0] err_count;
   logic bit_full, err_full;
   logic [BIT_CNT_W-1:0] bit_count_lat;
   logic [ERR_CNT_W-1:0] err_count_lat;
   logic latch_q, latch_rise;
   logic [5:0] match_run;
   logic [WIN_BITS-1:0] err_hist;
   logic [6:0] win_cnt;
   logic [6:0] next_win_cnt;
   logic lock_gain, lock_drop;
   logic run_val;
   logic [4:0] run_len;
   logic [4:0] next_run_len;
   logic zero_hit, one_hit;
   logic one_after_zeros, zero_after_ones;
   logic stat_rd, evt_rd, ctrl_wr;
   logic [DATA_W-1:0] stat_word;

   // ***********************************************************
   // Bit comparison and counters
   // ***********************************************************
   assign bit_step = ce_i & rx_bit_en_i;
   assign mismatch = rx_bit_i ^ exp_bit_i;
   assign err_step = (sync_state == SYNC_LOCKED) & mismatch;

   // Bit counter is not gated by lock state
   brcs_sat_cnt #(.W(BIT_CNT_W)) u_bit_cnt (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .inc_i(rx_bit_en_i), .count_o(bit_count), .full_o(bit_full)
   );

   brcs_sat_cnt #(.W(ERR_CNT_W)) u_err_cnt (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .inc_i(rx_bit_en_i & err_step), .count_o(err_count), .full_o(err_full)
   );

   // ***********************************************************
   // Count snapshot
   // ***********************************************************
   assign latch_rise = ce_i & ctrl.latch & ~latch_q;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         latch_q <= 1'b0;
      end else if (ce_i) begin
         latch_q <= ctrl.latch;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         bit_count_lat <= '0;
         err_count_lat <= '0;
      end else if (latch_rise) begin
         bit_count_lat <= bit_count;
         err_count_lat <= err_count;
      end
   end

   // ***********************************************************
   // Lock search and loss window
   // ***********************************************************
   always_comb begin
      next_win_cnt = win_cnt + {6'b0, mismatch} - {6'b0, err_hist[WIN_BITS-1]};
   end

   assign lock_gain = bit_step & (sync_state == SYNC_SEARCH) & ~mismatch
                    & (match_run == SYNC_MATCH_BITS - 6'd1);
   assign lock_drop = bit_step & (sync_state == SYNC_LOCKED)
                    & (next_win_cnt >= WIN_ERR_LIMIT);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sync_state <= SYNC_SEARCH;
      end else if (lock_gain) begin
         sync_state <= SYNC_LOCKED;
      end else if (lock_drop) begin
         sync_state <= SYNC_SEARCH;
      end
   end

   // Consecutive matches while searching
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         match_run <= '0;
      end else if (bit_step) begin
         if (sync_state != SYNC_SEARCH || lock_gain || mismatch) begin
            match_run <= '0;
         end else begin
            match_run <= match_run + 6'd1;
         end
      end
   end

   // Sliding 64-bit error history, cleared at every lock change
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         err_hist <= '0;
         win_cnt <= '0;
      end else if (lock_gain || lock_drop) begin
         err_hist <= '0;
         win_cnt <= '0;
      end else if (bit_step && sync_state == SYNC_LOCKED) begin
         err_hist <= {err_hist[WIN_BITS-2:0], mismatch};
         win_cnt <= next_win_cnt;
      end
   end

   assign in_sync_o = (sync_state == SYNC_LOCKED);
   assign searching_o = (sync_state == SYNC_SEARCH);

   // ***********************************************************
   // Runs of zeros and ones
   // ***********************************************************
   always_comb begin
      if (rx_bit_i != run_val) begin
         next_run_len = 5'd1;
      end else if (run_len == RUN_LEN) begin
         next_run_len = RUN_LEN;
      end else begin
         next_run_len = run_len + 5'd1;
      end
   end

   assign zero_hit = bit_step & ~rx_bit_i & (run_len != RUN_LEN)
                   & (next_run_len == RUN_LEN);
   assign one_hit = bit_step & rx_bit_i & (run_len != RUN_LEN)
                  & (next_run_len == RUN_LEN);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         run_val <= 1'b0;
         run_len <= '0;
      end else if (bit_step) begin
         run_val <= rx_bit_i;
         run_len <= next_run_len;
      end
   end

   // Opposite value seen since the run flag last latched
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         one_after_zeros <= 1'b0;
         zero_after_ones <= 1'b0;
      end else begin
         if (zero_hit) begin
            one_after_zeros <= 1'b0;
         end else if (bit_step && rx_bit_i) begin
            one_after_zeros <= 1'b1;
         end
         if (one_hit) begin
            zero_after_ones <= 1'b0;
         end else if (bit_step && !rx_bit_i) begin
            zero_after_ones <= 1'b1;
         end
      end
   end

   // ***********************************************************
   // Latched status flags
   // ***********************************************************
   assign stat_rd = ce_i & rd_i & (addr_i == STAT_OFS);
   assign evt_rd = ce_i & rd_i & (addr_i == EVT_OFS);

   brcs_sticky u_eco (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .set_i(err_full), .clr_i(stat_rd), .flag_o(flags.err_ovf)
   );
   brcs_sticky u_bco (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .set_i(bit_full), .clr_i(stat_rd), .flag_o(flags.bit_ovf)
   );
   brcs_sticky u_bed (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .set_i(bit_step & err_step), .clr_i(stat_rd), .flag_o(flags.bit_err)
   );
   brcs_sticky u_los (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .set_i(lock_drop), .clr_i(stat_rd), .flag_o(flags.lock_lost)
   );
   brcs_sticky u_ra0 (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .set_i(zero_hit), .clr_i(stat_rd & one_after_zeros),
      .flag_o(flags.all_zeros)
   );
   brcs_sticky u_ra1 (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .set_i(one_hit), .clr_i(stat_rd & zero_after_ones),
      .flag_o(flags.all_ones)
   );
   brcs_sticky u_chg (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .set_i(lock_gain | lock_drop), .clr_i(evt_rd), .flag_o(flags.lock_chg)
   );

   assign irq_o = (ctrl.ovf_irq_en & (flags.err_ovf | flags.bit_ovf))
                | (ctrl.err_irq_en & flags.bit_err)
                | (ctrl.sync_irq_en & flags.lock_chg);

   // ***********************************************************
   // Register port
   // ***********************************************************
   assign ctrl_wr = ce_i & wr_i & (addr_i == CTRL_OFS);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ctrl <= '{default: 1'b0};
      end else if (ctrl_wr) begin
         ctrl.latch <= wdata_i[CTRL_LATCH_BIT];
         ctrl.ovf_irq_en <= wdata_i[CTRL_OVF_IRQ_BIT];
         ctrl.err_irq_en <= wdata_i[CTRL_ERR_IRQ_BIT];
         ctrl.sync_irq_en <= wdata_i[CTRL_SYNC_IRQ_BIT];
      end
   end

   always_comb begin
      stat_word = STAT_RESET;
      stat_word[STAT_SYNC_BIT] = in_sync_o;
      stat_word[STAT_ECO_BIT] = flags.err_ovf;
      stat_word[STAT_BCO_BIT] = flags.bit_ovf;
      stat_word[STAT_BED_BIT] = flags.bit_err;
      stat_word[STAT_LOS_BIT] = flags.lock_lost;
      stat_word[STAT_RA0_BIT] = flags.all_zeros;
      stat_word[STAT_RA1_BIT] = flags.all_ones;
      stat_word[STAT_ERR_LSB +: 8] = err_count_lat[7:0];
   end

   // Read data stand one cycle after the strobe, otherwise zero
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else if (ce_i) begin
         rdata_o <= '0;
         if (rd_i) begin
            unique case (addr_i)
               CTRL_OFS: begin
                  rdata_o <= CTRL_RESET;
                  rdata_o[CTRL_LATCH_BIT] <= ctrl.latch;
                  rdata_o[CTRL_OVF_IRQ_BIT] <= ctrl.ovf_irq_en;
                  rdata_o[CTRL_ERR_IRQ_BIT] <= ctrl.err_irq_en;
                  rdata_o[CTRL_SYNC_IRQ_BIT] <= ctrl.sync_irq_en;
               end
               BIT_CNT_LO_OFS: rdata_o <= bit_count_lat[15:0];
               BIT_CNT_HI_OFS: rdata_o <= bit_count_lat[31:16];
               STAT_OFS: rdata_o <= stat_word;
               ERR_CNT_HI_OFS: rdata_o <= err_count_lat[23:8];
               EVT_OFS: rdata_o <= {15'h0000, flags.lock_chg};
               default: rdata_o <= '0;
            endcase
         end
      end
   end

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_last_match;
      sync_state == SYNC_SEARCH && match_run == 6'd31 && bit_step && !mismatch;
   endsequence

   sequence s_locked_then_lost;
      sync_state == SYNC_LOCKED ##1 sync_state == SYNC_SEARCH;
   endsequence

   AST_BIT_STEP: assert property (
      bit_step && bit_count != '1 |=> bit_count == $past(bit_count) + 32'd1)
      else $error("bit counter did not step");
   AST_BIT_HOLD: assert property (
      bit_full || bit_count == '1 |=> bit_count == '1 && (flags.bit_ovf || !$past(bit_full)))
      else $error("bit counter left full or flag clear");
   AST_ERR_STEP: assert property (
      bit_step && in_sync_o && mismatch && err_count != '1
      |=> err_count == $past(err_count) + 24'd1)
      else $error("error counter did not step");
   AST_ERR_SEARCH: assert property (
      searching_o |=> err_count == $past(err_count))
      else $error("error counted while searching");
   AST_LATCH_COPY: assert property (
      latch_rise |=> bit_count_lat == $past(bit_count) && err_count_lat == $past(err_count))
      else $error("counts not captured on latch edge");
   AST_LOCK_GAIN: assert property (
      s_last_match |=> in_sync_o ##0 match_run == 6'd0)
      else $error("lock not taken after 32 matches");
   AST_LOCK_DROP: assert property (
      lock_drop |=> searching_o && win_cnt == 7'd0)
      else $error("lock held after six errors in window");
   AST_LOS_FLAG: assert property (
      s_locked_then_lost |-> flags.lock_lost)
      else $error("lock lost flag not set");
   AST_SET_WINS: assert property (
      stat_rd && bit_step && err_step |=> flags.bit_err)
      else $error("bit error flag lost to a read");
   AST_RA0_HOLD: assert property (
      flags.all_zeros && !one_after_zeros && !zero_hit |=> flags.all_zeros)
      else $error("all-zeros flag cleared without a one");
   AST_STAT_LOW: assert property (
      stat_rd |=> rdata_o[15:8] == $past(err_count_lat[7:0]) && rdata_o[7] == 1'b0)
      else $error("error count low byte misplaced");
   AST_IRQ_ERR: assert property (
      ctrl.err_irq_en && flags.bit_err |-> irq_o)
      else $error("bit error interrupt missing");

endmodule // brcs_top
`default_nettype wire

// [include/brcs_pkg.sv]
// Constants, register map and carrier types for the receive pattern checker.
// Assumes a 16-bit register port with 12-bit byte addresses.
package brcs_pkg;

   // ***********************************************************
   // Register map
   // ***********************************************************
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 16;
   localparam logic [11:0] CTRL_OFS = 12'h500;
   localparam logic [11:0] BIT_CNT_LO_OFS = 12'h510;
   localparam logic [11:0] BIT_CNT_HI_OFS = 12'h514;
   localparam logic [11:0] STAT_OFS = 12'h518;
   localparam logic [11:0] ERR_CNT_HI_OFS = 12'h51c;
   localparam logic [11:0] EVT_OFS = 12'h520;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] STAT_RESET = 16'h0000;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int unsigned CTRL_LATCH_BIT = 3;
   localparam int unsigned CTRL_OVF_IRQ_BIT = 13;
   localparam int unsigned CTRL_ERR_IRQ_BIT = 14;
   localparam int unsigned CTRL_SYNC_IRQ_BIT = 15;
   localparam int unsigned STAT_SYNC_BIT = 0;
   localparam int unsigned STAT_ECO_BIT = 1;
   localparam int unsigned STAT_BCO_BIT = 2;
   localparam int unsigned STAT_BED_BIT = 3;
   localparam int unsigned STAT_LOS_BIT = 4;
   localparam int unsigned STAT_RA0_BIT = 5;
   localparam int unsigned STAT_RA1_BIT = 6;
   localparam int unsigned STAT_ERR_LSB = 8;
   localparam int unsigned EVT_CHG_BIT = 0;

   // ***********************************************************
   // Counts and thresholds
   // ***********************************************************
   localparam int unsigned BIT_CNT_W = 32;
   localparam int unsigned ERR_CNT_W = 24;
   localparam int unsigned WIN_BITS = 64;
   localparam logic [5:0] SYNC_MATCH_BITS = 6'd32;
   localparam logic [6:0] WIN_ERR_LIMIT = 7'd6;
   localparam logic [4:0] RUN_LEN = 5'd31;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef enum logic {SYNC_SEARCH, SYNC_LOCKED} brcs_sync_e;

   typedef struct packed {
      logic sync_irq_en;
      logic err_irq_en;
      logic ovf_irq_en;
      logic latch;
   } brcs_ctrl_s;

   typedef struct packed {
      logic all_ones;
      logic all_zeros;
      logic lock_lost;
      logic bit_err;
      logic bit_ovf;
      logic err_ovf;
      logic lock_chg;
   } brcs_flags_s;

endpackage

// [tb/brcs_rx_source.sv]
// Bit source standing in for the received line and the pattern regenerator.
// Assumes the bench raises run_i for each bit slot, one bit per clock.
`timescale 1ns/1ps
`default_nettype none
module brcs_rx_source (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic flip_i,
   input wire logic [1:0] mode_i,
   output logic rx_bit_o,
   output logic rx_bit_en_o,
   output logic exp_bit_o
);
   logic [6:0] lfsr;
   logic last_bit;
   logic ref_bit;

   // Mode 0 pseudorandom, 1 constant zeros, 2 constant ones
   always_comb begin
      case (mode_i)
         2'd1: ref_bit = 1'b0;
         2'd2: ref_bit = 1'b1;
         default: ref_bit = lfsr[0];
      endcase
   end

   assign exp_bit_o = ref_bit;
   assign rx_bit_en_o = run_i;
   // Outside a bit slot the line shows the inverse of the last bit sent
   assign rx_bit_o = run_i ? (ref_bit ^ flip_i) : ~last_bit;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         lfsr <= 7'h7f;
         last_bit <= 1'b0;
      end else if (run_i) begin
         lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
         last_bit <= ref_bit ^ flip_i;
      end
   end
endmodule // brcs_rx_source
`default_nettype wire

// [tb/tb_brcs_top.sv]
// Self-checking bench for the receive pattern checker.
// Assumes the design carries its own assertions; drives bits via the source model.
`timescale 1ns/1ps
`default_nettype none
module tb_brcs_top;
   import brcs_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic run = 1'b0;
   logic flip = 1'b0;
   logic [1:0] mode = 2'd0;
   logic ce = 1'b1;
   logic rx_bit, rx_en, exp_bit, searching, in_sync, irq;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] got;
   int errors = 0;
   int cmp_count = 0;

   always #12.5 sys_clk_i = ~sys_clk_i;

   brcs_top i_brcs_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
      .rx_bit_i(rx_bit), .rx_bit_en_i(rx_en), .exp_bit_i(exp_bit), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .searching_o(searching),
      .in_sync_o(in_sync), .irq_o(irq));

   brcs_rx_source i_brcs_rx_source (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .run_i(run), .flip_i(flip), .mode_i(mode), .rx_bit_o(rx_bit),
      .rx_bit_en_o(rx_en), .exp_bit_o(exp_bit));

   // ***********************************************************
   // Bus, bit and compare tasks
   // ***********************************************************
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_i);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
      @(posedge sys_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_i);
      rd <= 1'b0;
      #1;
      got = rdata;
      chk($sformatf("reg %h", a), exp, got);
   endtask

   task automatic send(input int n, input logic f, input logic [1:0] m);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk_i);
         run <= 1'b1;
         flip <= f;
         mode <= m;
      end
      @(posedge sys_clk_i);
      run <= 1'b0;
      flip <= 1'b0;
      #1;
   endtask

   task automatic bit_chk(input string name, input logic exp, input logic seen);
      chk(name, {15'h0000, exp}, {15'h0000, seen});
   endtask

   // ***********************************************************
   // Scenarios
   // ***********************************************************
   task automatic t_reset;
      bit_chk("searching", 1'b1, searching);
      rd_chk(STAT_OFS, 16'h0000);
      wr_reg(ERR_CNT_HI_OFS, 16'hffff);
      rd_chk(ERR_CNT_HI_OFS, 16'h0000);
      wr_reg(12'h7fc, 16'hffff);
      rd_chk(12'h7fc, 16'h0000);
      wr_reg(CTRL_OFS, 16'hffff);
      rd_chk(CTRL_OFS, 16'he008);
      wr_reg(CTRL_OFS, 16'h0000);
   endtask

   task automatic t_lock;
      wr_reg(CTRL_OFS, 16'h8000);
      send(31, 1'b0, 2'd0);
      bit_chk("in_sync", 1'b0, in_sync);
      send(1, 1'b0, 2'd0);
      bit_chk("in_sync", 1'b1, in_sync);
      rd_chk(STAT_OFS, 16'h0001);
      bit_chk("irq", 1'b1, irq);
      rd_chk(EVT_OFS, 16'h0001);
      bit_chk("irq", 1'b0, irq);
   endtask

   task automatic t_errors;
      wr_reg(CTRL_OFS, 16'h4000);
      send(1, 1'b1, 2'd0);
      @(posedge sys_clk_i);
      #1;
      bit_chk("irq", 1'b1, irq);
      rd_chk(STAT_OFS, 16'h0009);
      rd_chk(STAT_OFS, 16'h0001);
      bit_chk("irq", 1'b0, irq);
      send(4, 1'b1, 2'd0);
      @(posedge sys_clk_i);
      #1;
      bit_chk("in_sync", 1'b1, in_sync);
      send(1, 1'b1, 2'd0);
      @(posedge sys_clk_i);
      #1;
      bit_chk("searching", 1'b1, searching);
      send(2, 1'b1, 2'd0);
      send(32, 1'b0, 2'd0);
      bit_chk("in_sync", 1'b1, in_sync);
      rd_chk(STAT_OFS, 16'h0019);
      rd_chk(STAT_OFS, 16'h0001);
   endtask

   task automatic t_latch;
      wr_reg(CTRL_OFS, 16'h0008);
      rd_chk(BIT_CNT_LO_OFS, 16'h0048);
      rd_chk(BIT_CNT_HI_OFS, 16'h0000);
      rd_chk(STAT_OFS, 16'h0601);
      rd_chk(ERR_CNT_HI_OFS, 16'h0000);
      send(5, 1'b0, 2'd0);
      wr_reg(CTRL_OFS, 16'h0008);
      rd_chk(BIT_CNT_LO_OFS, 16'h0048);
      wr_reg(CTRL_OFS, 16'h0000);
      wr_reg(CTRL_OFS, 16'h0008);
      rd_chk(BIT_CNT_LO_OFS, 16'h004d);
   endtask

   task automatic t_runs;
      logic [15:0] m;
      for (int v = 0; v < 2; v++) begin
         m = 16'h0001 << (5 + v);
         send(1, 1'b0, 2'(2 - v));
         send(30, 1'b0, 2'(v + 1));
         // Upper byte 06 is the error count of the last snapshot
         rd_chk(STAT_OFS, 16'h0601);
         send(1, 1'b0, 2'(v + 1));
         rd_chk(STAT_OFS, 16'h0601 | m);
         rd_chk(STAT_OFS, 16'h0601 | m);
         send(1, 1'b0, 2'(2 - v));
         rd_chk(STAT_OFS, 16'h0601 | m);
         rd_chk(STAT_OFS, 16'h0601);
      end
   endtask

   task automatic t_freeze;
      @(posedge sys_clk_i);
      ce <= 1'b0;
      send(3, 1'b1, 2'd0);
      @(posedge sys_clk_i);
      ce <= 1'b1;
      wr_reg(CTRL_OFS, 16'h0000);
      wr_reg(CTRL_OFS, 16'h0008);
      rd_chk(BIT_CNT_LO_OFS, 16'h008f);
      rd_chk(STAT_OFS, 16'h0601);
      // Errored bit and clearing read in the same cycle
      fork
         send(1, 1'b1, 2'd0);
         rd_chk(STAT_OFS, 16'h0601);
      join
      rd_chk(STAT_OFS, 16'h0609);
   endtask

   // ***********************************************************
   // Verdict and run control
   // ***********************************************************
   task automatic final_report;
      if (errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge sys_clk_i);
      errors++;
      final_report;
   end

   initial begin
      repeat (10) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      #1;
      t_reset;
      t_lock;
      t_errors;
      t_latch;
      t_runs;
      t_freeze;
      final_report;
   end
endmodule // tb_brcs_top
`default_nettype wire
